/* design/rrq_pkg.sv */
package rrq_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] RRQ_OFF_DATA = 8'h00;
  localparam logic [7:0] RRQ_OFF_STATUS = 8'h04;
  localparam logic [7:0] RRQ_OFF_COUNT = 8'h08;
  localparam logic [7:0] RRQ_OFF_CONFIG = 8'h0C;
  localparam logic [7:0] RRQ_OFF_FLAGS = 8'h10;
  localparam logic [7:0] RRQ_OFF_STROBE = 8'h14;
  localparam logic [7:0] RRQ_OFF_IOCFG = 8'h18;
  localparam logic [7:0] RRQ_OFF_CORR = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // status: frame active, non-empty, threshold, channel clear, overflow
  localparam int RRQ_ST_FRAME = 0;
  localparam int RRQ_ST_NONEMPTY = 1;
  localparam int RRQ_ST_THR = 2;
  localparam int RRQ_ST_CCA = 3;
  localparam int RRQ_ST_OVF = 4;
  // config: threshold level in [6:0]
  localparam int RRQ_CFG_THR_LSB = 0;
  localparam int RRQ_CFG_ADDR_EN = 8;
  localparam int RRQ_CFG_ERR_EN = 9;
  // flags
  localparam int RRQ_FL_SFD = 0;
  localparam int RRQ_FL_THR = 1;
  // strobe
  localparam int RRQ_SB_FLUSH = 0;
  // io config: route enables [3:0], polarity [7:4]
  localparam int RRQ_IO_POL_LSB = 4;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam int RRQ_DEPTH = 128;
  localparam logic [6:0] RRQ_THR_RST = 7'h00;
  localparam logic [4:0] RRQ_CORR_RST = 5'h00;
  localparam logic [7:0] RRQ_IOCFG_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing: receiver byte rate
  // ----------------------------------------------------------------
  localparam int RRQ_CLK_HZ = 10_000_000;
  localparam int RRQ_RX_KBPS = 250;
  localparam int RRQ_BYTE_CYC = (RRQ_CLK_HZ / 1000 * 8) / RRQ_RX_KBPS;

endpackage

/* design/rrq_top.sv */
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - pulse dma trigger when queue leaves empty
// - pulse dma trigger on read leaving data
// - receive delimiter sets frame-start flag, interrupt
// - frame active until last data unit byte
// - address failure drops frame active at once when enabled
// - non-empty from first byte until empty
// - byte count equals bytes stored
// - threshold high while count exceeds level
// - threshold waits for address pass when enabled
// - threshold high when packet last byte stored
// - packet-only threshold clears after one read
// - queue holds at most 128 bytes
// - overflow: error interrupt if enabled, non-empty low, threshold high
// - overflow keeps stored bytes readable
// - after overflow accept nothing until flush
// - transmit delimiter sets frame-start flag, interrupt
// - transmit frame active ends at length or underflow
// - transmit underflow raises error interrupt if enabled
// - non-empty and threshold status bits follow receive queue only
// - statuses routable to debug pins, per polarity
// - bytes written at receiver rate, drained by bus reads up to one per clock
// - flush strobe empties whole queue
// - data read pops the oldest byte
module rrq_top #(
  parameter int DEPTH = rrq_pkg::RRQ_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_sfd_done,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic rx_byte_last,
  input wire logic addr_pass,
  input wire logic addr_fail,
  input wire logic tx_sfd_done,
  input wire logic tx_frame_done,
  input wire logic tx_underflow,
  input wire logic channel_clear_in,
  output logic radio_dma_trig,
  output logic radio_irq_req,
  output logic radio_error_irq,
  output logic [3:0] debug_pins,
  output logic [4:0] correlation_threshold
);
  import rrq_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [CW-1:0] frame_len_r;
  logic overflow_r;
  logic discard_r;
  logic addr_ok_r;
  logic pkt_done_r;
  logic frame_active_status_r;
  logic frame_start_irq_flag_r;
  logic threshold_irq_flag_r;
  logic thr_prev_r;
  logic [6:0] rx_threshold_level_r;
  logic addr_en_r;
  logic err_en_r;
  logic [7:0] io_config_first_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  // ----------------------------------------------------------------
  // bus request qualification
  // ----------------------------------------------------------------
  logic acc;
  logic rd_acc;
  logic pop;
  logic push;
  logic ovf_evt;
  logic flush;
  logic flag_wr;
  logic [CW-1:0] drop;
  logic rx_nonempty_status;
  logic rx_threshold_status;
  logic [3:0] stat_vec;

  assign acc = hsel && htrans[1] && hready;
  assign rd_acc = acc && !hwrite;
  // a read of an empty queue returns zero and removes nothing
  assign pop = rd_acc && hit(haddr, RRQ_OFF_DATA) && (count_r != '0);
  assign flush = wr_pend_r && hit({24'h000000, wr_addr_r}, RRQ_OFF_STROBE)
    && hwdata[RRQ_SB_FLUSH];
  assign flag_wr = wr_pend_r && hit({24'h000000, wr_addr_r}, RRQ_OFF_FLAGS);

  // bytes are taken as the demodulator delivers them, one per byte time
  // a byte that meets the address failure belongs to the dropped frame
  assign push = rx_byte_valid && !overflow_r && !discard_r && !(addr_fail && addr_en_r)
    && (count_r != CNT_FULL) && !flush;
  assign ovf_evt = rx_byte_valid && !overflow_r && !discard_r && !(addr_fail && addr_en_r)
    && (count_r == CNT_FULL) && !flush;
  // a failed address discards the frame's bytes so far
  assign drop = (addr_fail && addr_en_r) ? frame_len_r : '0;

  assign count_nxt = count_r + CW'(push) - CW'(pop) - drop;

  // ----------------------------------------------------------------
  // queue storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= rx_byte_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + PW'(push) - drop[PW-1:0];
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // frame tracking: length so far, address verdict, discard
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_len_r <= '0;
      discard_r <= 1'b0;
      addr_ok_r <= 1'b0;
    end else if (flush || rx_sfd_done) begin
      frame_len_r <= '0;
      discard_r <= 1'b0;
      addr_ok_r <= 1'b0;
    end else begin
      if (addr_fail && addr_en_r) begin
        frame_len_r <= '0;
        discard_r <= 1'b1;
      end else if (push) begin
        frame_len_r <= frame_len_r + CW'(1);
      end
      if (addr_pass) begin
        addr_ok_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // overflow: stored bytes stay, new ones wait for a flush
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      overflow_r <= 1'b0;
    end else if (ovf_evt) begin
      overflow_r <= 1'b1;
    end else if (flush) begin
      overflow_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status derivation
  // ----------------------------------------------------------------
  // non-empty and threshold statuses look only at the receive queue, whatever transmit does
  assign rx_nonempty_status = (count_r != '0) && !overflow_r;
  assign rx_threshold_status = overflow_r || pkt_done_r
    || ((count_r > CW'(rx_threshold_level_r)) && (!addr_en_r || addr_ok_r));
  assign stat_vec = {channel_clear_in, rx_threshold_status, rx_nonempty_status,
    frame_active_status_r};

  // packet completion holds threshold until one byte is read; set wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pkt_done_r <= 1'b0;
    end else if (push && rx_byte_last) begin
      pkt_done_r <= 1'b1;
    end else if (pop || flush) begin
      pkt_done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_active_status_r <= 1'b0;
    end else if (rx_sfd_done || tx_sfd_done) begin
      frame_active_status_r <= 1'b1;
    end else if ((rx_byte_valid && rx_byte_last) || (addr_fail && addr_en_r)
        || tx_frame_done || tx_underflow || flush) begin
      frame_active_status_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags and request pulses
  // ----------------------------------------------------------------
  // flags are write-zero-to-clear; a set in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_start_irq_flag_r <= 1'b0;
    end else if (rx_sfd_done || tx_sfd_done) begin
      frame_start_irq_flag_r <= 1'b1;
    end else if (flag_wr && !hwdata[RRQ_FL_SFD]) begin
      frame_start_irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      thr_prev_r <= 1'b0;
      threshold_irq_flag_r <= 1'b0;
    end else begin
      thr_prev_r <= rx_threshold_status;
      if (rx_threshold_status && !thr_prev_r) begin
        threshold_irq_flag_r <= 1'b1;
      end else if (flag_wr && !hwdata[RRQ_FL_THR]) begin
        threshold_irq_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      radio_irq_req <= 1'b0;
      radio_error_irq <= 1'b0;
    end else begin
      radio_irq_req <= rx_sfd_done || tx_sfd_done
        || (rx_threshold_status && !thr_prev_r);
      radio_error_irq <= err_en_r && (ovf_evt || tx_underflow);
    end
  end

  // ----------------------------------------------------------------
  // dma trigger
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      radio_dma_trig <= 1'b0;
    end else begin
      radio_dma_trig <= !flush && ((push && (count_r == '0))
        || (pop && (count_nxt != '0)));
    end
  end

  // ----------------------------------------------------------------
  // debug routing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      debug_pins <= 4'h0;
    end else begin
      debug_pins <= io_config_first_r[3:0]
        & (stat_vec ^ io_config_first_r[RRQ_IO_POL_LSB +: 4]);
    end
  end

  // ----------------------------------------------------------------
  // bus slave: writes land in the data phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= acc && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_threshold_level_r <= RRQ_THR_RST;
      addr_en_r <= 1'b0;
      err_en_r <= 1'b0;
      io_config_first_r <= RRQ_IOCFG_RST;
      correlation_threshold <= RRQ_CORR_RST;
    end else if (wr_pend_r) begin
      if (wr_addr_r == RRQ_OFF_CONFIG) begin
        rx_threshold_level_r <= hwdata[RRQ_CFG_THR_LSB +: 7];
        addr_en_r <= hwdata[RRQ_CFG_ADDR_EN];
        err_en_r <= hwdata[RRQ_CFG_ERR_EN];
      end
      if (wr_addr_r == RRQ_OFF_IOCFG) begin
        io_config_first_r <= hwdata[7:0];
      end
      // software is expected to write twenty here
      if (wr_addr_r == RRQ_OFF_CORR) begin
        correlation_threshold <= hwdata[4:0];
      end
    end
  end

  // read data is captured at the address-phase edge so it stands as a flop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (rd_acc) begin
      hrdata <= 32'h00000000;
      if (hit(haddr, RRQ_OFF_DATA) && (count_r != '0)) begin
        hrdata <= {24'h000000, mem[rd_ptr_r]};
      end
      if (hit(haddr, RRQ_OFF_STATUS)) begin
        hrdata <= {27'h0000000, overflow_r, stat_vec};
      end
      if (hit(haddr, RRQ_OFF_COUNT)) begin
        hrdata <= 32'(count_r);
      end
      if (hit(haddr, RRQ_OFF_CONFIG)) begin
        hrdata <= {22'h000000, err_en_r, addr_en_r, 1'b0, rx_threshold_level_r};
      end
      if (hit(haddr, RRQ_OFF_FLAGS)) begin
        hrdata <= {30'h00000000, threshold_irq_flag_r, frame_start_irq_flag_r};
      end
      if (hit(haddr, RRQ_OFF_IOCFG)) begin
        hrdata <= {24'h000000, io_config_first_r};
      end
      if (hit(haddr, RRQ_OFF_CORR)) begin
        hrdata <= {27'h0000000, correlation_threshold};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_dma_first_byte: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (push && !flush && count_r == '0) |=> radio_dma_trig)
    else $error("dma trigger missing on first byte");

  a_dma_read_more: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pop && !flush && !push && count_r > CW'(1) && drop == '0) |=> radio_dma_trig)
    else $error("dma trigger missing on read with data left");

  a_count_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
    count_r <= CNT_FULL)
    else $error("queue count above depth");

  a_count_track: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (push && !pop && !flush && drop == '0) |=> count_r == $past(count_r) + CW'(1))
    else $error("count did not follow a stored byte");

  a_flush_empty: assert property (@(posedge clk_sys) disable iff (!rst_b)
    flush |=> (count_r == '0 && !rx_nonempty_status && !overflow_r))
    else $error("flush left data in queue");

  a_ovf_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ovf_evt |=> (!rx_nonempty_status && rx_threshold_status
      && radio_error_irq == $past(err_en_r)))
    else $error("overflow status wrong");

  a_ovf_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (overflow_r && !flush) |-> !push)
    else $error("byte stored while overflowed");

  a_sfd_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_sfd_done || tx_sfd_done) |=> (frame_start_irq_flag_r && radio_irq_req
      && frame_active_status_r))
    else $error("frame start flag not set");

  a_fail_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (addr_fail && addr_en_r && !rx_sfd_done && !tx_sfd_done) |=> !frame_active_status_r)
    else $error("frame active held after address failure");

  a_pkt_thr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (push && rx_byte_last) |=> rx_threshold_status ##0 pkt_done_r)
    else $error("threshold not raised at packet end");

  a_tx_underflow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tx_underflow && err_en_r && !tx_sfd_done && !rx_sfd_done) |=> (radio_error_irq
      && !frame_active_status_r))
    else $error("underflow not reported");

endmodule

`default_nettype wire

/* sim/rrq_radio_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// demodulator and transmitter event source
// ----------------------------------------------------------------
module rrq_radio_model (
  input wire logic clk_sys,
  output logic rx_sfd_done,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte_data,
  output logic rx_byte_last,
  output logic addr_pass,
  output logic addr_fail,
  output logic tx_sfd_done,
  output logic tx_frame_done,
  output logic tx_underflow
);
  logic [5:0] ev;
  assign {tx_underflow, tx_frame_done, tx_sfd_done, addr_fail, addr_pass, rx_sfd_done} = ev;

  initial begin
    ev = 6'h00;
    rx_byte_valid = 1'b0;
    rx_byte_last = 1'b0;
    rx_byte_data = 8'h00;
  end

  // one event, one cycle wide: 0 sfd, 1 pass, 2 fail, 3 tx sfd, 4 tx done, 5 underflow
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev <= 6'h01 << k;
    @(posedge clk_sys);
    ev <= 6'h00;
  endtask

  // idle noise on event lines; harmless only with no frame and gating off
  task automatic noise(input logic [5:0] m);
    @(posedge clk_sys);
    ev <= m;
    rx_byte_last <= ^m;
    @(posedge clk_sys);
    ev <= 6'h00;
    rx_byte_last <= 1'b0;
  endtask

  // a byte stands one cycle; afterwards the lines show its inverse, never a stale copy
  // v low makes the slot an idle one
  task automatic send(input logic v, input logic [7:0] b, input logic l, input int gap);
    @(posedge clk_sys);
    rx_byte_valid <= v;
    rx_byte_data <= b;
    rx_byte_last <= l;
    @(posedge clk_sys);
    rx_byte_valid <= 1'b0;
    rx_byte_last <= 1'b0;
    rx_byte_data <= ~b;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

/* sim/radio_rx_queue_status_test.sv */
`timescale 1ns/1ns
`default_nettype none

module radio_rx_queue_status_test;
  import rrq_pkg::*;
  logic clk_sys, rst_b, hsel, hwrite, hreadyout, hresp, channel_clear_in;
  logic [31:0] haddr, hwdata, hrdata, rv, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] debug_pins;
  logic [4:0] correlation_threshold;
  logic radio_dma_trig, radio_irq_req, radio_error_irq, rx_byte_valid, rx_byte_last;
  logic rx_sfd_done, addr_pass, addr_fail, tx_sfd_done, tx_frame_done, tx_underflow;
  logic [7:0] rx_byte_data;
  logic [31:0] seed;
  logic [7:0] q[$];
  int miscompares, compares, cyc, dma_n, irq_n, err_n, d0, i0, e0;

  rrq_top dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_sfd_done(rx_sfd_done),
    .rx_byte_valid(rx_byte_valid), .rx_byte_data(rx_byte_data),
    .rx_byte_last(rx_byte_last), .addr_pass(addr_pass), .addr_fail(addr_fail),
    .tx_sfd_done(tx_sfd_done), .tx_frame_done(tx_frame_done), .tx_underflow(tx_underflow),
    .channel_clear_in(channel_clear_in), .radio_dma_trig(radio_dma_trig),
    .radio_irq_req(radio_irq_req), .radio_error_irq(radio_error_irq),
    .debug_pins(debug_pins), .correlation_threshold(correlation_threshold)
  );

  rrq_radio_model radio (
    .clk_sys(clk_sys), .rx_sfd_done(rx_sfd_done), .rx_byte_valid(rx_byte_valid),
    .rx_byte_data(rx_byte_data), .rx_byte_last(rx_byte_last), .addr_pass(addr_pass),
    .addr_fail(addr_fail), .tx_sfd_done(tx_sfd_done), .tx_frame_done(tx_frame_done),
    .tx_underflow(tx_underflow)
  );

  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // pulse counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (radio_dma_trig === 1'b1) dma_n <= dma_n + 1;
    if (radio_irq_req === 1'b1) irq_n <= irq_n + 1;
    if (radio_error_irq === 1'b1) err_n <= err_n + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] stx(logic f, logic ne, logic th, logic ov);
    logic [31:0] r;
    r = 32'h0;
    r[RRQ_ST_FRAME] = f;
    r[RRQ_ST_NONEMPTY] = ne;
    r[RRQ_ST_THR] = th;
    r[RRQ_ST_CCA] = channel_clear_in;
    r[RRQ_ST_OVF] = ov;
    return r;
  endfunction

  function automatic logic [31:0] cfg(int thr, logic a, logic e);
    return 32'(thr) | (32'(a) << RRQ_CFG_ADDR_EN) | (32'(e) << RRQ_CFG_ERR_EN);
  endfunction

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // single word transfer; waits on hready in both phases, bench timeout ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    // next address phase is idle: select, address and direction are don't-care
    hsel <= 1'(rnd());
    htrans <= 2'h0;
    haddr <= rnd();
    hwrite <= 1'(rnd() >> 3);
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask

  task automatic pop();
    rd_chk(RRQ_OFF_DATA, {24'h000000, q.pop_front()});
    chk(32'(hresp), 32'h0);
  endtask

  task automatic drain();
    while (q.size() > 0) pop();
  endtask

  // the model queue holds only what the device may accept
  // random idle slots (valid low) fall between the bytes
  task automatic rx(input int n, input logic last, input logic keep, input int gap);
    logic [7:0] b;
    logic vb;
    int i;
    i = 0;
    while (i < n) begin
      b = 8'(rnd());
      vb = 1'(rnd() >> 7);
      if (vb && keep && q.size() < RRQ_DEPTH) q.push_back(b);
      radio.send(vb, b, vb && last && i == n - 1, vb ? gap + int'(rnd() & 32'h3) : 0);
      i += int'(vb);
    end
  endtask

  task automatic snap();
    d0 = dma_n;
    i0 = irq_n;
    e0 = err_n;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    channel_clear_in = 1'b0;
    seed = 32'h5F;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    channel_clear_in <= 1'(rnd());
    rd_chk(RRQ_OFF_STATUS, stx(0, 0, 0, 0));
    rd_chk(RRQ_OFF_COUNT, 32'h0);
    wr(RRQ_OFF_CORR, 32'h14);
    rd_chk(RRQ_OFF_CORR, 32'h14);
    chk(32'(correlation_threshold), 32'h14);
    rd_chk(8'h20, 32'h0);
    // event noise with no frame, address and error gating off: nothing may happen
    radio.noise(6'(rnd()) & 6'h36);
    wait_cy(2);
    chk(32'(irq_n + err_n + dma_n), 32'h0);
    rd_chk(RRQ_OFF_STATUS, stx(0, 0, 0, 0));
    // one frame at the receiver byte rate, threshold far above it
    wr(RRQ_OFF_CONFIG, cfg(100, 0, 0));
    snap();
    // either delimiter kind opens the frame after reset
    radio.pulse(3 * int'(rnd() & 32'h1));
    wait_cy(2);
    chk(32'(irq_n - i0), 32'h1);
    rd_chk(RRQ_OFF_FLAGS, 32'h1);
    rd_chk(RRQ_OFF_STATUS, stx(1, 0, 0, 0));
    rx(6, 1'b1, 1'b1, RRQ_BYTE_CYC);
    wait_cy(2);
    chk(32'(dma_n - d0), 32'h1);
    chk(32'(irq_n - i0), 32'h2);
    rd_chk(RRQ_OFF_STATUS, stx(0, 1, 1, 0));
    rd_chk(RRQ_OFF_COUNT, 32'h6);
    snap();
    pop();
    wait_cy(1);
    chk(32'(dma_n - d0), 32'h1);
    rd_chk(RRQ_OFF_STATUS, stx(0, 1, 0, 0));
    snap();
    drain();
    wait_cy(1);
    chk(32'(dma_n - d0), 32'h4);
    rd_chk(RRQ_OFF_STATUS, stx(0, 0, 0, 0));
    rd_chk(RRQ_OFF_DATA, 32'h0);
    wr(RRQ_OFF_FLAGS, 32'h0);
    // count threshold at its boundary
    wr(RRQ_OFF_CONFIG, cfg(3, 0, 0));
    radio.pulse(0);
    rx(4, 1'b0, 1'b1, 0);
    rd_chk(RRQ_OFF_STATUS, stx(1, 1, 1, 0));
    rx(1, 1'b1, 1'b1, 0);
    rd_chk(RRQ_OFF_COUNT, 32'h5);
    pop();
    rd_chk(RRQ_OFF_STATUS, stx(0, 1, 1, 0));
    pop();
    rd_chk(RRQ_OFF_STATUS, stx(0, 1, 0, 0));
    drain();
    // address recognition: pass, then a failing frame
    wr(RRQ_OFF_CONFIG, cfg(2, 1, 0));
    radio.pulse(0);
    rx(4, 1'b0, 1'b1, 0);
    rd_chk(RRQ_OFF_STATUS, stx(1, 1, 0, 0));
    radio.pulse(1);
    wait_cy(1);
    rd_chk(RRQ_OFF_STATUS, stx(1, 1, 1, 0));
    rx(1, 1'b1, 1'b1, 0);
    drain();
    radio.pulse(0);
    rx(3, 1'b0, 1'b0, 0);
    radio.pulse(2);
    rd_chk(RRQ_OFF_STATUS, stx(0, 0, 0, 0));
    rx(2, 1'b1, 1'b0, 0);
    rd_chk(RRQ_OFF_COUNT, 32'h0);
    // overflow with the error interrupt enabled
    wr(RRQ_OFF_CONFIG, cfg(127, 0, 1));
    snap();
    radio.pulse(0);
    rx(129, 1'b0, 1'b1, 0);
    wait_cy(2);
    chk(32'(err_n - e0), 32'h1);
    bus(1'b0, RRQ_OFF_STATUS, 32'h0);
    chk(rv & 32'h16, 32'h14);
    rd_chk(RRQ_OFF_COUNT, 32'h80);
    pop();
    rx(1, 1'b0, 1'b0, 0);
    rd_chk(RRQ_OFF_COUNT, 32'h7F);
    wr(RRQ_OFF_STROBE, 32'h1);
    wr(RRQ_OFF_STROBE, 32'h1);
    q.delete();
    rd_chk(RRQ_OFF_STATUS, stx(0, 0, 0, 0));
    rd_chk(RRQ_OFF_COUNT, 32'h0);
    // transmit beside a non-empty receive queue
    radio.pulse(0);
    rx(1, 1'b1, 1'b1, 0);
    wr(RRQ_OFF_FLAGS, 32'h0);
    snap();
    radio.pulse(3);
    wait_cy(2);
    chk(32'(irq_n - i0), 32'h1);
    rd_chk(RRQ_OFF_FLAGS, 32'h1);
    rd_chk(RRQ_OFF_STATUS, stx(1, 1, 1, 0));
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      wr(RRQ_OFF_IOCFG, v & 32'hFF);
      wait_cy(2);
      chk(32'(debug_pins), 32'(v[3:0] & ({channel_clear_in, 3'h7} ^ v[7:4])));
    end
    radio.pulse(5);
    wait_cy(2);
    chk(32'(err_n - e0), 32'h1);
    rd_chk(RRQ_OFF_STATUS, stx(0, 1, 1, 0));
    wr(RRQ_OFF_CONFIG, cfg(127, 0, 0));
    radio.pulse(3);
    radio.pulse(4);
    wait_cy(1);
    rd_chk(RRQ_OFF_STATUS, stx(0, 1, 1, 0));
    radio.pulse(3);
    radio.pulse(5);
    wait_cy(2);
    chk(32'(err_n - e0), 32'h1);
    drain();
    wrap_up();
  end
endmodule

`default_nettype wire
